//--- design/timer_reload_capture_regs.svh
// register addresses, field positions, reset values and counts of the timer block
// assumes it is included by bare name wherever these constants are needed
`ifndef TIMER_RELOAD_CAPTURE_REGS_SVH
`define TIMER_RELOAD_CAPTURE_REGS_SVH

// special function register addresses on the core's register port
`define ADDR_TIMER_RUN_FLAGS 8'h00
`define ADDR_TIMER_MODE_REG 8'h01
`define ADDR_T0_LOW_BYTE 8'h02
`define ADDR_T1_LOW_BYTE 8'h03
`define ADDR_T0_HIGH_BYTE 8'h04
`define ADDR_T1_HIGH_BYTE 8'h05
`define ADDR_TIMER_THREE_CONTROL 8'h06
`define ADDR_T3_MODE_REG 8'h07
`define ADDR_T3_CAPTURE_LOW 8'h08
`define ADDR_T3_CAPTURE_HIGH 8'h09
`define ADDR_T3_LOW_BYTE 8'h0A
`define ADDR_T3_HIGH_BYTE 8'h0B
`define ADDR_POWER_CONTROL_REG 8'h0C

// run/flag register fields
`define RF_T1_OVERFLOW_FLAG 7
`define RF_T1_RUN_BIT 6
`define RF_T0_OVERFLOW_FLAG 5
`define RF_T0_RUN_BIT 4

// timer mode register fields
`define TM_T1_GATE 7
`define TM_T1_COUNTER_SEL 6
`define TM_T1_MODE_HI 5
`define TM_T1_MODE_LO 4
`define TM_T0_GATE 3
`define TM_T0_COUNTER_SEL 2
`define TM_T0_MODE_HI 1
`define TM_T0_MODE_LO 0
`define MODE_AUTO_RELOAD 2'b10
`define MODE_SPLIT 2'b11

// timer three control fields
`define T3C_OVERFLOW_FLAG 7
`define T3C_EXTERNAL_FLAG 6
`define T3C_RX_CLOCK_SELECT 5
`define T3C_TX_CLOCK_SELECT 4
`define T3C_EXT_ENABLE 3
`define T3C_RUN_BIT 2
`define T3C_COUNTER_SELECT 1
`define T3C_CAPTURE_RELOAD_SELECT 0

// timer three mode register and power control fields
`define T3M_DOWN_COUNT_ENABLE 0
`define PC_PORT2_RX_CLOCK_SELECT 5
`define PC_PORT2_TX_CLOCK_SELECT 4

// byte reset value and down count underflow load value
`define BYTE_RESET 8'h00
`define WORD_ALL_ONES 16'hFFFF

// synchronised pin vector positions
`define PIN_T0_COUNT 0
`define PIN_T1_COUNT 1
`define PIN_T3_COUNT 2
`define PIN_T3_TRIGGER 3
`define PIN_EXT_IRQ_ZERO 4
`define PIN_EXT_IRQ_ONE 5
`define PIN_COUNT 6

// oscillator clocks per machine cycle
`define OSC_PER_MACHINE_CYCLE 12
`define MC_COUNT_WIDTH 4

`endif

//--- design/timer_pkg.sv
// types shared by the timer block and its pin sampler
// assumes the register header sits on the include path
`include "timer_reload_capture_regs.svh"
package timer_pkg;

  typedef enum logic [1:0] {
    T3_CAPTURE,
    T3_RELOAD,
    T3_BAUD
  } t3_mode_e;

  typedef struct packed {
    logic [`PIN_COUNT-1:0] sync1;
    logic [`PIN_COUNT-1:0] sync2;
    logic [`PIN_COUNT-1:0] sample;
  } sampler_state_s;

  typedef struct packed {
    logic [`MC_COUNT_WIDTH-1:0] mc_cnt;
    logic t1_overflow_flag;
    logic t1_run_bit;
    logic t0_overflow_flag;
    logic t0_run_bit;
    logic [7:0] timer_mode_reg;
    logic [7:0] t0_low_byte;
    logic [7:0] t0_high_byte;
    logic [7:0] t1_low_byte;
    logic [7:0] t1_high_byte;
    logic [7:0] timer_three_control;
    logic down_count_enable;
    logic [7:0] t3_capture_low;
    logic [7:0] t3_capture_high;
    logic [7:0] t3_low_byte;
    logic [7:0] t3_high_byte;
    logic port2_rx_clock_select;
    logic port2_tx_clock_select;
    logic [7:0] rdata;
    logic uart1_rx_clk;
    logic uart1_tx_clk;
    logic uart2_rx_clk;
    logic uart2_tx_clk;
    logic t0_irq;
    logic t1_irq;
    logic t3_irq;
  } timer_state_s;

endpackage

//--- design/pin_sampler.sv
// two-flop synchroniser and once-per-machine-cycle falling edge sampler for the timer pins
// assumes mc_tick_i is a one-cycle pulse from the same clock domain
`include "timer_reload_capture_regs.svh"
module pin_sampler
  import timer_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // machine cycle strobe
  input wire logic mc_tick_i,
  // raw pins and results
  input wire logic [`PIN_COUNT-1:0] pins_i,
  output logic [`PIN_COUNT-1:0] level_o,
  output logic [`PIN_COUNT-1:0] fall_o
);

  sampler_state_s s;
  sampler_state_s next_s;

  always_comb begin
    next_s = s;
    next_s.sync1 = pins_i;
    next_s.sync2 = s.sync1;
    if (mc_tick_i) begin
      next_s.sample = s.sync2;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level_o = s.sync2;
  // high at the previous machine cycle sample, low now: one edge per two cycles at most
  assign fall_o = {`PIN_COUNT{mc_tick_i}} & s.sample & ~s.sync2;

endmodule

//--- design/timer_reload_capture_unit.sv
// timer block: basic timers in reload and split modes, third timer with capture, reload and baud clocking
// assumes the core writes and reads registers over the plain register port, one access per cycle
//
// Behaviour
// - reload mode counts low byte, reloads from high
// - timer zero reload mode matches timer one
// - timer one split mode freezes its count
// - timer zero low byte: independent split counter
// - timer zero high byte uses timer one controls
// - timer one stoppable by mode, keeps baud pulses
// - third timer counts cycles or falling pin edges
// - capture mode: 16-bit up counter sets overflow
// - trigger fall captures count and sets external flag
// - reload mode: overflow sets flag, reloads pair
// - reload mode trigger fall sets flag, forces reload unless down counting
// - clock selects force reload, ignore capture select
// - baud operation never sets overflow flag
// - overflow flag cleared by software only
// - external flag requests interrupt, software clears
// - port one receive clock source selection
// - port one transmit clock source selection
// - trigger ignored unless enabled, baud included
// - baud mode trigger is extra interrupt source
// - third timer counts only while run bit set
// - port two clock selects in power register
// - capture mode counts upward only
// - timer function counts once per machine cycle
// - counter function needs high then low sample
// - mode field codes reload and split
// - gate bit ties enable to interrupt pin
`include "timer_reload_capture_regs.svh"
module timer_reload_capture_unit
  import timer_pkg::*;
#(
  parameter int OSC_PER_MC = `OSC_PER_MACHINE_CYCLE
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // pins
  input wire logic t0_count_pin_i,
  input wire logic t1_count_pin_i,
  input wire logic t3_count_pin_i,
  input wire logic t3_trigger_input_i,
  input wire logic ext_irq_zero_pin_i,
  input wire logic ext_irq_one_pin_i,
  // interrupt controller
  input wire logic t0_vector_ack_i,
  input wire logic t1_vector_ack_i,
  input wire logic t3_irq_enable_i,
  output logic t0_irq_o,
  output logic t1_irq_o,
  output logic t3_irq_o,
  // serial baud clock pulses
  output logic uart1_rx_clk_o,
  output logic uart1_tx_clk_o,
  output logic uart2_rx_clk_o,
  output logic uart2_tx_clk_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // parameter check

  generate
    if (OSC_PER_MC < 2 || OSC_PER_MC > (1 << `MC_COUNT_WIDTH)) begin : g_bad_prescale
      $error("oscillator clocks per machine cycle out of range");
    end
  endgenerate

  localparam logic [`MC_COUNT_WIDTH-1:0] MC_LAST = `MC_COUNT_WIDTH'(OSC_PER_MC - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [16:0] add_one16(input logic [15:0] v);
    add_one16 = {1'b0, v} + 17'h00001;
  endfunction

  function automatic logic [8:0] add_one8(input logic [7:0] v);
    add_one8 = {1'b0, v} + 9'h001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state and pins

  timer_state_s s;
  timer_state_s next_s;

  logic mc_tick;
  logic [`PIN_COUNT-1:0] pins;
  logic [`PIN_COUNT-1:0] pin_level;
  logic [`PIN_COUNT-1:0] pin_fall;

  assign mc_tick = (s.mc_cnt == MC_LAST);
  assign pins = {ext_irq_one_pin_i, ext_irq_zero_pin_i, t3_trigger_input_i,
                 t3_count_pin_i, t1_count_pin_i, t0_count_pin_i};

  pin_sampler u_pin_sampler (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .mc_tick_i(mc_tick),
    .pins_i(pins),
    .level_o(pin_level),
    .fall_o(pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  logic [1:0] t0_mode;
  logic [1:0] t1_mode;
  logic t0_split;
  logic t0_en;
  logic t1_en;
  logic t0_inc;
  logic t1_inc;
  logic t3_inc;
  logic t3_baud;
  logic t3_trig;
  logic t3_ovf;
  logic t1_ovf;
  logic set_tf0;
  logic set_tf1;
  logic set_tf2;
  logic set_t3_external_flag;
  logic wr_run_flags;
  logic wr_t3_control;
  logic [8:0] sum8;
  logic [16:0] sum16;
  logic [15:0] cnt16;
  logic [15:0] next16;
  logic [15:0] rcap16;
  t3_mode_e t3_mode;

  always_comb begin
    next_s = s;
    next_s.mc_cnt = mc_tick ? '0 : s.mc_cnt + `MC_COUNT_WIDTH'(1);
    t0_mode = {s.timer_mode_reg[`TM_T0_MODE_HI], s.timer_mode_reg[`TM_T0_MODE_LO]};
    t1_mode = {s.timer_mode_reg[`TM_T1_MODE_HI], s.timer_mode_reg[`TM_T1_MODE_LO]};
    t0_split = (t0_mode == `MODE_SPLIT);
    // while timer zero is split its high byte owns the timer one run bit
    t0_en = s.t0_run_bit & (~s.timer_mode_reg[`TM_T0_GATE] | pin_level[`PIN_EXT_IRQ_ZERO]);
    t1_en = (s.t1_run_bit | t0_split) & (~s.timer_mode_reg[`TM_T1_GATE] | pin_level[`PIN_EXT_IRQ_ONE]);
    t0_inc = mc_tick & t0_en & (s.timer_mode_reg[`TM_T0_COUNTER_SEL] ? pin_fall[`PIN_T0_COUNT] : 1'b1);
    t1_inc = mc_tick & t1_en & (s.timer_mode_reg[`TM_T1_COUNTER_SEL] ? pin_fall[`PIN_T1_COUNT] : 1'b1);
    set_tf0 = 1'b0;
    set_tf1 = 1'b0;
    set_tf2 = 1'b0;
    set_t3_external_flag = 1'b0;
    t1_ovf = 1'b0;
    t3_ovf = 1'b0;
    sum8 = 9'h000;
    sum16 = 17'h00000;

    // timer zero
    if (t0_inc) begin
      case (t0_mode)
        `MODE_AUTO_RELOAD: begin
          sum8 = add_one8(s.t0_low_byte);
          set_tf0 = sum8[8];
          next_s.t0_low_byte = sum8[8] ? s.t0_high_byte : sum8[7:0];
        end
        `MODE_SPLIT: begin
          sum8 = add_one8(s.t0_low_byte);
          set_tf0 = sum8[8];
          next_s.t0_low_byte = sum8[7:0];
        end
        default: begin
          sum16 = add_one16({s.t0_high_byte, s.t0_low_byte});
          set_tf0 = sum16[16];
          next_s.t0_high_byte = sum16[15:8];
          next_s.t0_low_byte = sum16[7:0];
        end
      endcase
    end
    // split high byte: machine cycles only, timer one run bit and flag
    if (mc_tick && t0_split && s.t1_run_bit) begin
      sum8 = add_one8(s.t0_high_byte);
      set_tf1 = sum8[8];
      next_s.t0_high_byte = sum8[7:0];
    end

    // timer one; split mode holds the count like a cleared run bit
    if (t1_inc && t1_mode != `MODE_SPLIT) begin
      if (t1_mode == `MODE_AUTO_RELOAD) begin
        sum8 = add_one8(s.t1_low_byte);
        t1_ovf = sum8[8];
        next_s.t1_low_byte = sum8[8] ? s.t1_high_byte : sum8[7:0];
      end else begin
        sum16 = add_one16({s.t1_high_byte, s.t1_low_byte});
        t1_ovf = sum16[16];
        next_s.t1_high_byte = sum16[15:8];
        next_s.t1_low_byte = sum16[7:0];
      end
    end
    // with timer zero split its flag belongs to the high byte; pulses still reach the uarts
    if (t1_ovf && !t0_split) begin
      set_tf1 = 1'b1;
    end

    // third timer
    t3_baud = s.timer_three_control[`T3C_RX_CLOCK_SELECT] | s.timer_three_control[`T3C_TX_CLOCK_SELECT] |
              s.port2_rx_clock_select | s.port2_tx_clock_select;
    if (t3_baud) begin
      t3_mode = T3_BAUD;
    end else if (s.timer_three_control[`T3C_CAPTURE_RELOAD_SELECT]) begin
      t3_mode = T3_CAPTURE;
    end else begin
      t3_mode = T3_RELOAD;
    end
    t3_inc = mc_tick & s.timer_three_control[`T3C_RUN_BIT] &
             (s.timer_three_control[`T3C_COUNTER_SELECT] ? pin_fall[`PIN_T3_COUNT] : 1'b1);
    t3_trig = s.timer_three_control[`T3C_EXT_ENABLE] & pin_fall[`PIN_T3_TRIGGER];
    cnt16 = {s.t3_high_byte, s.t3_low_byte};
    rcap16 = {s.t3_capture_high, s.t3_capture_low};
    next16 = cnt16;
    if (t3_inc) begin
      if (t3_mode == T3_RELOAD && s.down_count_enable && !pin_level[`PIN_T3_TRIGGER]) begin
        if (cnt16 == rcap16) begin
          next16 = `WORD_ALL_ONES;
          set_tf2 = 1'b1;
        end else begin
          next16 = cnt16 - 16'h0001;
        end
      end else begin
        // capture mode lands here whatever the down count bit says
        sum16 = add_one16(cnt16);
        if (t3_mode == T3_BAUD) begin
          t3_ovf = sum16[16];
        end else begin
          set_tf2 = sum16[16];
        end
        if (sum16[16] && t3_mode != T3_CAPTURE) begin
          next16 = rcap16;
        end else begin
          next16 = sum16[15:0];
        end
      end
    end
    if (t3_trig) begin
      set_t3_external_flag = 1'b1;
      case (t3_mode)
        T3_CAPTURE: begin
          next_s.t3_capture_high = s.t3_high_byte;
          next_s.t3_capture_low = s.t3_low_byte;
        end
        T3_RELOAD: begin
          // in down count mode the trigger pin is the direction, not a reload
          if (!s.down_count_enable) begin
            next16 = rcap16;
          end
        end
        default: begin
        end
      endcase
    end
    next_s.t3_high_byte = next16[15:8];
    next_s.t3_low_byte = next16[7:0];

    // software writes win over counting for data, lose to hardware sets for flags
    wr_run_flags = sfr_wr_i && (sfr_addr_i == `ADDR_TIMER_RUN_FLAGS);
    wr_t3_control = sfr_wr_i && (sfr_addr_i == `ADDR_TIMER_THREE_CONTROL);
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        `ADDR_TIMER_MODE_REG: next_s.timer_mode_reg = sfr_wdata_i;
        `ADDR_T0_LOW_BYTE: next_s.t0_low_byte = sfr_wdata_i;
        `ADDR_T1_LOW_BYTE: next_s.t1_low_byte = sfr_wdata_i;
        `ADDR_T0_HIGH_BYTE: next_s.t0_high_byte = sfr_wdata_i;
        `ADDR_T1_HIGH_BYTE: next_s.t1_high_byte = sfr_wdata_i;
        `ADDR_T3_MODE_REG: next_s.down_count_enable = sfr_wdata_i[`T3M_DOWN_COUNT_ENABLE];
        `ADDR_T3_CAPTURE_LOW: next_s.t3_capture_low = sfr_wdata_i;
        `ADDR_T3_CAPTURE_HIGH: next_s.t3_capture_high = sfr_wdata_i;
        `ADDR_T3_LOW_BYTE: next_s.t3_low_byte = sfr_wdata_i;
        `ADDR_T3_HIGH_BYTE: next_s.t3_high_byte = sfr_wdata_i;
        `ADDR_POWER_CONTROL_REG: begin
          next_s.port2_rx_clock_select = sfr_wdata_i[`PC_PORT2_RX_CLOCK_SELECT];
          next_s.port2_tx_clock_select = sfr_wdata_i[`PC_PORT2_TX_CLOCK_SELECT];
        end
        default: begin
        end
      endcase
    end
    if (wr_run_flags) begin
      next_s.t1_run_bit = sfr_wdata_i[`RF_T1_RUN_BIT];
      next_s.t0_run_bit = sfr_wdata_i[`RF_T0_RUN_BIT];
    end
    next_s.t0_overflow_flag = (wr_run_flags ? sfr_wdata_i[`RF_T0_OVERFLOW_FLAG] :
                               (s.t0_overflow_flag & ~t0_vector_ack_i)) | set_tf0;
    next_s.t1_overflow_flag = (wr_run_flags ? sfr_wdata_i[`RF_T1_OVERFLOW_FLAG] :
                               (s.t1_overflow_flag & ~t1_vector_ack_i)) | set_tf1;
    if (wr_t3_control) begin
      next_s.timer_three_control[5:0] = sfr_wdata_i[5:0];
    end
    // no hardware clear of the third timer flags
    next_s.timer_three_control[`T3C_OVERFLOW_FLAG] = (wr_t3_control ? sfr_wdata_i[`T3C_OVERFLOW_FLAG] :
                                                      s.timer_three_control[`T3C_OVERFLOW_FLAG]) | set_tf2;
    next_s.timer_three_control[`T3C_EXTERNAL_FLAG] = (wr_t3_control ? sfr_wdata_i[`T3C_EXTERNAL_FLAG] :
                                                      s.timer_three_control[`T3C_EXTERNAL_FLAG]) | set_t3_external_flag;

    // read data, one cycle behind the address
    case (sfr_addr_i)
      `ADDR_TIMER_RUN_FLAGS: next_s.rdata = {s.t1_overflow_flag, s.t1_run_bit, s.t0_overflow_flag,
                                             s.t0_run_bit, 4'h0};
      `ADDR_TIMER_MODE_REG: next_s.rdata = s.timer_mode_reg;
      `ADDR_T0_LOW_BYTE: next_s.rdata = s.t0_low_byte;
      `ADDR_T1_LOW_BYTE: next_s.rdata = s.t1_low_byte;
      `ADDR_T0_HIGH_BYTE: next_s.rdata = s.t0_high_byte;
      `ADDR_T1_HIGH_BYTE: next_s.rdata = s.t1_high_byte;
      `ADDR_TIMER_THREE_CONTROL: next_s.rdata = s.timer_three_control;
      `ADDR_T3_MODE_REG: next_s.rdata = {7'h00, s.down_count_enable};
      `ADDR_T3_CAPTURE_LOW: next_s.rdata = s.t3_capture_low;
      `ADDR_T3_CAPTURE_HIGH: next_s.rdata = s.t3_capture_high;
      `ADDR_T3_LOW_BYTE: next_s.rdata = s.t3_low_byte;
      `ADDR_T3_HIGH_BYTE: next_s.rdata = s.t3_high_byte;
      `ADDR_POWER_CONTROL_REG: next_s.rdata = {2'h0, s.port2_rx_clock_select, s.port2_tx_clock_select, 4'h0};
      default: next_s.rdata = `BYTE_RESET;
    endcase

    // baud pulses; the uart itself picks which serial modes use them
    next_s.uart1_rx_clk = s.timer_three_control[`T3C_RX_CLOCK_SELECT] ? t3_ovf : t1_ovf;
    next_s.uart1_tx_clk = s.timer_three_control[`T3C_TX_CLOCK_SELECT] ? t3_ovf : t1_ovf;
    next_s.uart2_rx_clk = s.port2_rx_clock_select ? t3_ovf : t1_ovf;
    next_s.uart2_tx_clk = s.port2_tx_clock_select ? t3_ovf : t1_ovf;

    // interrupt requests follow the flags in the same cycle
    next_s.t0_irq = next_s.t0_overflow_flag;
    next_s.t1_irq = next_s.t1_overflow_flag;
    next_s.t3_irq = t3_irq_enable_i & (next_s.timer_three_control[`T3C_OVERFLOW_FLAG] |
                                       next_s.timer_three_control[`T3C_EXTERNAL_FLAG]);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign sfr_rdata_o = s.rdata;
  assign t0_irq_o = s.t0_irq;
  assign t1_irq_o = s.t1_irq;
  assign t3_irq_o = s.t3_irq;
  assign uart1_rx_clk_o = s.uart1_rx_clk;
  assign uart1_tx_clk_o = s.uart1_tx_clk;
  assign uart2_rx_clk_o = s.uart2_rx_clk;
  assign uart2_tx_clk_o = s.uart2_tx_clk;

endmodule

//--- tb/timer_reload_capture_props.sv
// concurrent checks on the ports of the timer block
// assumes one clock domain and the register map of the design header
module timer_reload_capture_props #(
  parameter int OSC_PER_MC = 12
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic t0_vector_ack_i,
  input wire logic t1_vector_ack_i,
  input wire logic t3_irq_enable_i,
  input wire logic t0_irq_o,
  input wire logic t1_irq_o,
  input wire logic t3_irq_o,
  input wire logic uart1_tx_clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  // mode write then a quiet cycle on the same address
  sequence s_mode_wr;
    sfr_wr_i && sfr_addr_i == 8'h01 ##1 !sfr_wr_i && sfr_addr_i == 8'h01;
  endsequence
  a_irq_needs_enable: assert property (!t3_irq_enable_i |=> !t3_irq_o)
    else $error("third timer irq while disabled");
  a_t3_flag_sticky: assert property ($fell(t3_irq_o) |->
    !$past(t3_irq_enable_i) || ($past(sfr_wr_i) && $past(sfr_addr_i) == 8'h06))
    else $error("third timer flag dropped by hardware");
  a_t0_flag_clear: assert property ($fell(t0_irq_o) |->
    $past(t0_vector_ack_i) || ($past(sfr_wr_i) && $past(sfr_addr_i) == 8'h00))
    else $error("timer zero flag dropped without cause");
  a_t1_flag_clear: assert property ($fell(t1_irq_o) |->
    $past(t1_vector_ack_i) || ($past(sfr_wr_i) && $past(sfr_addr_i) == 8'h00))
    else $error("timer one flag dropped without cause");
  a_uart_one_pulse: assert property (uart1_tx_clk_o |=> !uart1_tx_clk_o)
    else $error("baud pulse longer than one cycle");
  a_mode_read_back: assert property (s_mode_wr |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
    else $error("mode register read back differs");
  a_unmapped_zero: assert property (sfr_addr_i > 8'h0C |=> sfr_rdata_o == 8'h00)
    else $error("unmapped address reads nonzero");
  a_power_bits: assert property (sfr_addr_i == 8'h0C |=> (sfr_rdata_o & 8'hCF) == 8'h00)
    else $error("power control unused bits set");
  a_down_mode_bits: assert property (sfr_addr_i == 8'h07 |=> sfr_rdata_o[7:1] == 7'h00)
    else $error("third mode register unused bits set");
  a_reset_quiet: assert property ($fell(rst_i) |-> !(t0_irq_o || t1_irq_o || t3_irq_o))
    else $error("irq active right after reset");
endmodule
bind timer_reload_capture_unit timer_reload_capture_props #(.OSC_PER_MC(OSC_PER_MC)) props (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .t0_vector_ack_i(t0_vector_ack_i),
  .t1_vector_ack_i(t1_vector_ack_i), .t3_irq_enable_i(t3_irq_enable_i), .t0_irq_o(t0_irq_o),
  .t1_irq_o(t1_irq_o), .t3_irq_o(t3_irq_o), .uart1_tx_clk_o(uart1_tx_clk_o));

//--- tb/tb_top.sv
// self-checking bench for the timer block, register port and pins driven directly
// assumes a shortened machine cycle of 2 clocks; count pins idle high
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, we = 0, en = 0, t0_ack = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
  // pn[3] is the timer zero gate pin
  logic [3:0] pn = 4'hF;
  logic t0_irq, t1_irq, t3_irq;
  logic [3:0] uo;
  int n_fail = 0, checks = 0, cyc = 0;
  int nu[4];
  initial forever #50 clk = ~clk;
  timer_reload_capture_unit #(.OSC_PER_MC(2)) dut (
    .sys_clk_i(clk), .rst_i(rst), .sfr_addr_i(addr), .sfr_wr_i(we), .sfr_wdata_i(wd),
    .sfr_rdata_o(rdata), .t0_count_pin_i(pn[0]), .t1_count_pin_i(1'b1), .t3_count_pin_i(pn[1]),
    .t3_trigger_input_i(pn[2]), .ext_irq_zero_pin_i(pn[3]), .ext_irq_one_pin_i(1'b1),
    .t0_vector_ack_i(t0_ack), .t1_vector_ack_i(1'b0), .t3_irq_enable_i(en), .t0_irq_o(t0_irq),
    .t1_irq_o(t1_irq), .t3_irq_o(t3_irq), .uart1_rx_clk_o(uo[0]), .uart1_tx_clk_o(uo[1]),
    .uart2_rx_clk_o(uo[2]), .uart2_tx_clk_o(uo[3]));
  ////////////////////////////////////////////////////////////////
  // pulse counters and hang guard; off the launching edge so no pulse is missed or doubled
  always @(negedge clk) begin
    cyc++;
    for (int k = 0; k < 4; k++) nu[k] += uo[k];
    if (cyc == 6000) begin
      n_fail++;
      close_out();
    end
  end
  task close_out;
    $display("mismatches %0d of %0d checks", n_fail, checks);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    we = 1;
    @(negedge clk);
    we = 0;
    @(negedge clk);
  endtask
  // rdata answers one edge after the address
  task rdc(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    @(negedge clk);
    chk(rdata, e);
  endtask
  // levels held long enough for sync plus one tick
  task fall(input int k);
    pn[k] = 0;
    repeat (8) @(negedge clk);
    pn[k] = 1;
    repeat (8) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task t0_reload;
    wr(8'h01, 8'h06);
    rdc(8'h01, 8'h06);
    wr(8'h04, 8'hA5);
    wr(8'h02, 8'hFE);
    wr(8'h00, 8'h10);
    fall(0);
    rdc(8'h02, 8'hFF);
    chk(t0_irq, 1'b0);
    fall(0);
    chk(t0_irq, 1'b1);
    rdc(8'h02, 8'hA5);
    rdc(8'h04, 8'hA5);
    wr(8'h00, 8'h00);
    chk(t0_irq, 1'b0);
    // gate set, pin low: edges ignored until the pin rises
    pn[3] = 0;
    wr(8'h01, 8'h0E);
    wr(8'h00, 8'h10);
    fall(0);
    rdc(8'h02, 8'hA5);
    pn[3] = 1;
    fall(0);
    rdc(8'h02, 8'hA6);
    wr(8'h00, 8'h00);
  endtask
  task split;
    wr(8'h01, 8'h37);
    wr(8'h03, 8'h10);
    wr(8'h02, 8'hFE);
    wr(8'h04, 8'hFE);
    wr(8'h00, 8'h50);
    // high byte free-runs on ticks, so wait bounded
    repeat (40) if (!t1_irq) @(negedge clk);
    chk(t1_irq, 1'b1);
    chk(t0_irq, 1'b0);
    rdc(8'h03, 8'h10);
    fall(0);
    fall(0);
    chk(t0_irq, 1'b1);
    rdc(8'h02, 8'h00);
    // vectoring pulse clears the timer zero flag
    t0_ack = 1;
    @(negedge clk);
    t0_ack = 0;
    chk(t0_irq, 1'b0);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h00);
  endtask
  task t3_capture;
    wr(8'h0A, 8'hFE);
    wr(8'h0B, 8'hFF);
    wr(8'h06, 8'h0F);
    fall(1);
    fall(1);
    chk(t3_irq, 1'b0);
    en = 1;
    @(negedge clk);
    chk(t3_irq, 1'b1);
    fall(1);
    fall(2);
    rdc(8'h08, 8'h01);
    rdc(8'h09, 8'h00);
    rdc(8'h06, 8'hCF);
    wr(8'h06, 8'h0B);
    chk(t3_irq, 1'b0);
    fall(1);
    rdc(8'h0A, 8'h01);
  endtask
  task t3_reload;
    wr(8'h08, 8'h34);
    wr(8'h09, 8'h12);
    wr(8'h0A, 8'hFF);
    wr(8'h0B, 8'hFF);
    wr(8'h06, 8'h0E);
    fall(1);
    rdc(8'h0B, 8'h12);
    rdc(8'h06, 8'h8E);
    fall(1);
    fall(2);
    rdc(8'h0A, 8'h34);
    rdc(8'h06, 8'hCE);
    pn[2] = 0;
    wr(8'h07, 8'h01);
    rdc(8'h07, 8'h01);
    fall(1);
    rdc(8'h0A, 8'hFF);
    pn[2] = 1;
    wr(8'h07, 8'h00);
  endtask
  task baud;
    wr(8'h08, 8'hFE);
    wr(8'h09, 8'hFF);
    wr(8'h0A, 8'hFF);
    wr(8'h0B, 8'hFF);
    wr(8'h0C, 8'h10);
    rdc(8'h0C, 8'h10);
    wr(8'h06, 8'h3F);
    nu = '{default: 0};
    fall(1);
    chk(nu[0], 1);
    chk(nu[1], 1);
    chk(nu[2], 0);
    chk(nu[3], 1);
    rdc(8'h0A, 8'hFE);
    rdc(8'h06, 8'h3F);
    fall(2);
    rdc(8'h0A, 8'hFE);
    rdc(8'h06, 8'h7F);
    chk(t3_irq, 1'b1);
    rdc(8'h20, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge clk);
    rst = 0;
    t0_reload();
    split();
    t3_capture();
    t3_reload();
    baud();
    close_out();
  end
endmodule
